// ---- logic/pmc_pkg.sv ----
// Package with register map, field layout, mode codes and timing for the power-mode controller.
package pmc_pkg;

  // Register byte offsets.
  localparam logic [7:0] MODE_OFF      = 8'h00;
  localparam logic [7:0] ACT_TPL_OFF   = 8'h04;
  localparam logic [7:0] ALT_TPL_OFF   = 8'h08;
  localparam logic [7:0] WAKE_EN_OFF   = 8'h0c;
  localparam logic [7:0] WAKE_STAT_OFF = 8'h10;
  localparam logic [7:0] CTW_MASK_OFF  = 8'h14;
  localparam logic [7:0] CTW_CNT_OFF   = 8'h18;
  localparam logic [7:0] STATUS_OFF    = 8'h1c;

  // Mode codes in the mode control field.
  localparam logic [1:0] MODE_ACTIVE = 2'h0;
  localparam logic [1:0] MODE_ALT    = 2'h1;
  localparam logic [1:0] MODE_SLEEP  = 2'h2;
  localparam logic [1:0] MODE_HIBER  = 2'h3;

  // Field positions.
  localparam int TPL_CPU_BIT    = 0;
  localparam int CTW_CLR_BIT    = 0;
  localparam int STAT_WAKE_BIT  = 2;
  localparam int STAT_HOLD_BIT  = 3;
  localparam int RST_EXT_BIT    = 8;
  localparam int RST_WDT_BIT    = 9;
  localparam int RST_PRECISE_LOW_VOLTAGE_RESET_BIT   = 10;
  localparam int CTW_CNT_LSB    = 0;

  // Reset values.
  localparam logic [7:0]  ACT_TPL_RST  = 8'hff;
  localparam logic [7:0]  ALT_TPL_RST  = 8'hfe;
  localparam logic [7:0]  WAKE_EN_RST  = 8'h00;
  localparam logic [12:0] CTW_MASK_RST = 13'h03ff;

  // Wake sources allowed in each low-power mode.
  localparam logic [7:0] SLEEP_SRC_M = 8'h3f;
  localparam logic [7:0] HIBER_SRC_M = 8'h02;

  // Timing.
  localparam int CLK_PERIOD_NS = 10;
  localparam int SLEEP_WAKE_US = 15;
  localparam int HIBER_WAKE_US = 100;
  localparam logic [13:0] SLEEP_WAKE_CYC =
    14'((SLEEP_WAKE_US * 1000) / CLK_PERIOD_NS - 1);
  localparam logic [13:0] HIBER_WAKE_CYC_DEF =
    14'((HIBER_WAKE_US * 1000) / CLK_PERIOD_NS - 1);

  // Interrupt-type wake sources, bit 7 first.
  typedef struct packed {
    logic power_supervisor;
    logic universal_digital_block;
    logic low_voltage_detect;
    logic central_timewheel;
    logic rtc;
    logic i2c;
    logic pin_interrupt_unit;
    logic comparator;
  } pmc_wake_src_t;

  // Reset-type wake events.
  typedef struct packed {
    logic precise_low_voltage_reset;
    logic watchdog_reset;
    logic external_reset_pin_n;
  } pmc_rst_evt_t;

endpackage

// ---- logic/pmc_timewheel.sv ----
// 13-bit central timewheel, advanced on tick_1k while run is high, with a periodic interrupt.
`timescale 1ns/10ps
module pmc_timewheel (
  // Clock and reset.
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  // Control.
  input  wire logic        tick_1k,
  input  wire logic        run,
  input  wire logic        clear,
  input  wire logic [12:0] period_mask,
  // Results.
  output logic      [12:0] count_q,
  output logic             irq_q
);

  logic [12:0] count_d;

  assign count_d = count_q + 13'h0001;

  always_ff @(posedge clk_sys) begin
    if (!reset_n || clear) begin
      count_q <= 13'h0000;
    end else if (tick_1k && run) begin
      count_q <= count_d;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= tick_1k && run && !clear && ((count_d & period_mask) == 13'h0000);
    end
  end

  ctw_count_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (tick_1k && run && !clear) |=> (count_q == $past(count_q) + 13'h0001))
    else $error("Timewheel did not advance on tick.");

endmodule

// ---- logic/pmc_ctrl.sv ----
// Global power-mode controller with APB registers and wake sequencing.
`timescale 1ns/10ps
module pmc_ctrl #(
  parameter logic [13:0] HIBER_WAKE_CYC = pmc_pkg::HIBER_WAKE_CYC_DEF
) (
  // Clock and reset.
  input  wire logic                   clk_sys,
  input  wire logic                   reset_n,
  // APB slave.
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [7:0]             paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  // Wake and reset events.
  input  wire pmc_pkg::pmc_wake_src_t wake_src,
  input  wire pmc_pkg::pmc_rst_evt_t  rst_evt,
  input  wire logic                   tick_1k,
  // Power controls.
  output logic      [7:0]             subsys_clk_en,
  output logic      [1:0]             mode_q,
  output logic                        regulators_on,
  output logic                        regulator_buzz,
  output logic                        hiber_regulator_only,
  output logic                        io_hold,
  output logic                        mem_retain,
  output logic                        rtc_run,
  output logic                        ctw_irq
);

  typedef enum logic [2:0] {
    ST_ACTIVE,
    ST_ALT,
    ST_SLEEP,
    ST_HIBER,
    ST_WAKE_SLP,
    ST_WAKE_HIB
  } pmc_state_t;

  pmc_state_t  state_q;
  pmc_state_t  state_d;
  logic [7:0]  act_tpl_q;
  logic [7:0]  alt_tpl_q;
  logic [7:0]  wake_en_q;
  logic [10:0] wake_stat_q;
  logic [12:0] ctw_mask_q;
  logic [12:0] ctw_count;
  logic [13:0] cnt_q;
  logic [13:0] wait_q;
  logic [31:0] prdata_q;
  logic        pslverr_q;
  logic        wr_en;
  logic        mode_wr;
  logic [1:0]  mode_tgt;
  logic [7:0]  src_vec;
  logic [7:0]  src_en;
  logic [2:0]  rst_vec;
  logic        rst_any;
  logic        irq_wake;
  logic        wake_evt;
  logic        ctw_clear;
  logic        ctw_run;

  // Address decode shared by the read and write paths.
  function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] off);
    reg_hit = (addr == off);
  endfunction

  function automatic logic reg_mapped(input logic [7:0] addr);
    reg_mapped = reg_hit(addr, pmc_pkg::MODE_OFF) || reg_hit(addr, pmc_pkg::ACT_TPL_OFF) ||
                 reg_hit(addr, pmc_pkg::ALT_TPL_OFF) || reg_hit(addr, pmc_pkg::WAKE_EN_OFF) ||
                 reg_hit(addr, pmc_pkg::WAKE_STAT_OFF) || reg_hit(addr, pmc_pkg::CTW_MASK_OFF) ||
                 reg_hit(addr, pmc_pkg::CTW_CNT_OFF) || reg_hit(addr, pmc_pkg::STATUS_OFF);
  endfunction

  // Mode code shown for a controller state.
  function automatic logic [1:0] mode_code(input pmc_state_t st);
    case (st)
      ST_ALT:      mode_code = pmc_pkg::MODE_ALT;
      ST_SLEEP:    mode_code = pmc_pkg::MODE_SLEEP;
      ST_HIBER:    mode_code = pmc_pkg::MODE_HIBER;
      ST_WAKE_HIB: mode_code = pmc_pkg::MODE_HIBER;
      ST_WAKE_SLP: mode_code = pmc_pkg::MODE_SLEEP;
      default:     mode_code = pmc_pkg::MODE_ACTIVE;
    endcase
  endfunction

  assign pready   = 1'b1;
  assign prdata   = prdata_q;
  assign pslverr  = pslverr_q;
  assign wr_en    = psel && penable && pwrite && pready;
  assign mode_tgt = pwdata[1:0];
  assign mode_wr  = wr_en && reg_hit(paddr, pmc_pkg::MODE_OFF);
  assign ctw_clear = wr_en && reg_hit(paddr, pmc_pkg::CTW_CNT_OFF) && pwdata[pmc_pkg::CTW_CLR_BIT];

  // Wake event qualification.
  assign src_vec  = wake_src;
  assign src_en   = src_vec & wake_en_q;
  assign rst_vec  = {rst_evt.precise_low_voltage_reset, rst_evt.watchdog_reset,
                     !rst_evt.external_reset_pin_n};
  assign rst_any  = |rst_vec;
  assign irq_wake = |src_en;

  // Next-state logic.
  always_comb begin
    state_d  = state_q;
    wake_evt = 1'b0;
    case (state_q)
      ST_ACTIVE: begin
        if (rst_any || irq_wake) begin
          wake_evt = 1'b1;
        end else if (mode_wr) begin
          case (mode_tgt)
            pmc_pkg::MODE_ALT:   state_d = ST_ALT;
            pmc_pkg::MODE_SLEEP: state_d = ST_SLEEP;
            pmc_pkg::MODE_HIBER: state_d = ST_HIBER;
            default:             state_d = ST_ACTIVE;
          endcase
        end
      end
      ST_ALT: begin
        if (rst_any || irq_wake) begin
          wake_evt = 1'b1;
          state_d  = ST_ACTIVE;
        end else if (mode_wr) begin
          case (mode_tgt)
            pmc_pkg::MODE_ACTIVE: state_d = ST_ACTIVE;
            pmc_pkg::MODE_SLEEP:  state_d = ST_SLEEP;
            pmc_pkg::MODE_HIBER:  state_d = ST_HIBER;
            default:              state_d = ST_ALT;
          endcase
        end
      end
      ST_SLEEP: begin
        if (rst_any) begin
          wake_evt = 1'b1;
          state_d  = ST_ACTIVE;
        end else if (|(src_en & pmc_pkg::SLEEP_SRC_M)) begin
          state_d = ST_WAKE_SLP;
        end
      end
      ST_HIBER: begin
        if (!rst_evt.external_reset_pin_n) begin
          wake_evt = 1'b1;
          state_d  = ST_ACTIVE;
        end else if (|(src_en & pmc_pkg::HIBER_SRC_M)) begin
          state_d = ST_WAKE_HIB;
        end
      end
      ST_WAKE_SLP, ST_WAKE_HIB: begin
        if (rst_any || cnt_q == 14'h0000) begin
          wake_evt = 1'b1;
          state_d  = ST_ACTIVE;
        end
      end
      default: begin
        state_d = ST_ACTIVE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      state_q <= ST_ACTIVE;
    end else begin
      state_q <= state_d;
    end
  end

  // Wake interval counter.
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      cnt_q <= 14'h0000;
    end else if (state_q == ST_SLEEP) begin
      cnt_q <= pmc_pkg::SLEEP_WAKE_CYC - 14'h0001;
    end else if (state_q == ST_HIBER) begin
      cnt_q <= HIBER_WAKE_CYC - 14'h0001;
    end else if (cnt_q != 14'h0000) begin
      cnt_q <= cnt_q - 14'h0001;
    end
  end

  // Templates; a wake event re-enables the processor and beats a software clear.
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      act_tpl_q <= pmc_pkg::ACT_TPL_RST;
    end else begin
      if (wr_en && reg_hit(paddr, pmc_pkg::ACT_TPL_OFF)) begin
        act_tpl_q <= pwdata[7:0];
      end
      if (wake_evt) begin
        act_tpl_q[pmc_pkg::TPL_CPU_BIT] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      alt_tpl_q <= pmc_pkg::ALT_TPL_RST;
    end else if (wr_en && reg_hit(paddr, pmc_pkg::ALT_TPL_OFF)) begin
      alt_tpl_q <= pwdata[7:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      wake_en_q  <= pmc_pkg::WAKE_EN_RST;
      ctw_mask_q <= pmc_pkg::CTW_MASK_RST;
    end else begin
      if (wr_en && reg_hit(paddr, pmc_pkg::WAKE_EN_OFF)) begin
        wake_en_q <= pwdata[7:0];
      end
      if (wr_en && reg_hit(paddr, pmc_pkg::CTW_MASK_OFF)) begin
        ctw_mask_q <= pwdata[12:0];
      end
    end
  end

  // Sticky wake causes; write one to clear, a new event wins.
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      wake_stat_q <= 11'h000;
    end else begin
      wake_stat_q <= (wake_stat_q & ~((wr_en && reg_hit(paddr, pmc_pkg::WAKE_STAT_OFF)) ?
                     pwdata[10:0] : 11'h000)) | {rst_vec, src_en};
    end
  end

  // Registered read data and error, captured in the setup cycle.
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (psel && !penable) begin
      pslverr_q <= !reg_mapped(paddr);
      prdata_q  <= 32'h0000_0000;
      if (reg_hit(paddr, pmc_pkg::MODE_OFF)) begin
        prdata_q[1:0] <= mode_code(state_q);
      end
      if (reg_hit(paddr, pmc_pkg::ACT_TPL_OFF)) begin
        prdata_q[7:0] <= act_tpl_q;
      end
      if (reg_hit(paddr, pmc_pkg::ALT_TPL_OFF)) begin
        prdata_q[7:0] <= alt_tpl_q;
      end
      if (reg_hit(paddr, pmc_pkg::WAKE_EN_OFF)) begin
        prdata_q[7:0] <= wake_en_q;
      end
      if (reg_hit(paddr, pmc_pkg::WAKE_STAT_OFF)) begin
        prdata_q[10:0] <= wake_stat_q;
      end
      if (reg_hit(paddr, pmc_pkg::CTW_MASK_OFF)) begin
        prdata_q[12:0] <= ctw_mask_q;
      end
      if (reg_hit(paddr, pmc_pkg::CTW_CNT_OFF)) begin
        prdata_q[pmc_pkg::CTW_CNT_LSB +: 13] <= ctw_count;
      end
      if (reg_hit(paddr, pmc_pkg::STATUS_OFF)) begin
        prdata_q[1:0] <= mode_code(state_q);
        prdata_q[pmc_pkg::STAT_WAKE_BIT] <= (state_q == ST_WAKE_SLP) || (state_q == ST_WAKE_HIB);
        prdata_q[pmc_pkg::STAT_HOLD_BIT] <= io_hold;
      end
    end
  end

  // Power control outputs.
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      subsys_clk_en        <= pmc_pkg::ACT_TPL_RST;
      mode_q               <= pmc_pkg::MODE_ACTIVE;
      regulators_on        <= 1'b1;
      regulator_buzz       <= 1'b0;
      hiber_regulator_only <= 1'b0;
      io_hold              <= 1'b0;
      mem_retain           <= 1'b0;
      rtc_run              <= 1'b1;
    end else begin
      mode_q               <= mode_code(state_q);
      regulators_on        <= (state_q != ST_SLEEP) && (state_q != ST_HIBER);
      regulator_buzz       <= (state_q == ST_SLEEP);
      hiber_regulator_only <= (state_q == ST_HIBER);
      io_hold              <= (state_q == ST_HIBER) || (state_q == ST_WAKE_HIB);
      mem_retain           <= (state_q == ST_HIBER) || (state_q == ST_WAKE_HIB);
      rtc_run              <= ctw_run;
      case (state_q)
        ST_ACTIVE: subsys_clk_en <= act_tpl_q;
        ST_ALT:    subsys_clk_en <= alt_tpl_q;
        default:   subsys_clk_en <= 8'h00;
      endcase
    end
  end

  assign ctw_run = (state_q != ST_HIBER) && (state_q != ST_WAKE_HIB);

  pmc_timewheel u_timewheel (
    .clk_sys     (clk_sys),
    .reset_n     (reset_n),
    .tick_1k     (tick_1k),
    .run         (ctw_run),
    .clear       (ctw_clear),
    .period_mask (ctw_mask_q),
    .count_q     (ctw_count),
    .irq_q       (ctw_irq)
  );

  // Cycles spent in the current wake interval, for checking only.
  always_ff @(posedge clk_sys) begin
    if (!reset_n || (state_q != ST_WAKE_SLP && state_q != ST_WAKE_HIB)) begin
      wait_q <= 14'h0000;
    end else begin
      wait_q <= wait_q + 14'h0001;
    end
  end

  sequence alt_event_s;
    (state_q == ST_ALT) && (rst_any || irq_wake);
  endsequence

  sequence back_active_s;
    (state_q == ST_ACTIVE) && act_tpl_q[pmc_pkg::TPL_CPU_BIT];
  endsequence

  boot_active_a: assert property (@(posedge clk_sys)
    reset_n && $past(!reset_n) |-> (state_q == ST_ACTIVE) &&
    (subsys_clk_en == pmc_pkg::ACT_TPL_RST))
    else $error("Controller not active after reset.");

  wake_forces_active_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    alt_event_s |=> back_active_s)
    else $error("Wake event in alternate active did not restore active.");

  cpu_reenable_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    wake_evt |=> act_tpl_q[pmc_pkg::TPL_CPU_BIT])
    else $error("Processor not re-enabled on wake.");

  sleep_gating_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (state_q == ST_SLEEP) |=> (subsys_clk_en == 8'h00) && rtc_run && regulator_buzz)
    else $error("Sleep did not gate subsystems.");

  sleep_wake_time_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (state_q == ST_WAKE_SLP) |-> (wait_q < pmc_pkg::SLEEP_WAKE_CYC))
    else $error("Sleep wake interval too long.");

  hiber_wake_time_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (state_q == ST_WAKE_HIB) |-> (wait_q < HIBER_WAKE_CYC))
    else $error("Hibernate resume too long.");

  hiber_pin_only_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (state_q == ST_HIBER) && !src_en[1] && rst_evt.external_reset_pin_n
    |=> (state_q == ST_HIBER))
    else $error("Hibernate left without a pin interrupt.");

  hiber_hold_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (state_q == ST_HIBER) |=> io_hold && mem_retain && !rtc_run)
    else $error("Hibernate did not hold pins and memory.");

  entry_by_write_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (state_q == ST_ACTIVE) ##1 (state_q != ST_ACTIVE) |-> $past(mode_wr))
    else $error("Low-power mode entered without a mode write.");

  tpl_write_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    wr_en && reg_hit(paddr, pmc_pkg::ACT_TPL_OFF) && !wake_evt
    |=> act_tpl_q == $past(pwdata[7:0]))
    else $error("Active template write lost.");

endmodule

// ---- tb/pmc_ctrl_tb_top.sv ----
// Self-checking testbench for the power-mode controller.
`timescale 1ns/10ps
module pmc_ctrl_tb_top;
  localparam int HWC = 20;
  logic                   clk_sys = 1'b0;
  logic                   reset_n = 1'b0;
  logic                   psel = 1'b0;
  logic                   penable = 1'b0;
  logic                   pwrite = 1'b0;
  logic [7:0]             paddr = 8'h00;
  logic [31:0]            pwdata = 32'h0;
  logic [31:0]            prdata;
  logic                   pready;
  logic                   pslverr;
  pmc_pkg::pmc_wake_src_t wake_drv = 8'h00;
  pmc_pkg::pmc_wake_src_t wake_src;
  pmc_pkg::pmc_rst_evt_t  rst_evt = 3'h1;
  logic                   tick_1k = 1'b0;
  logic                   ctw_fb = 1'b0;
  logic [7:0]             subsys_clk_en;
  logic [1:0]             mode_q;
  logic                   regulators_on;
  logic                   regulator_buzz;
  logic                   hiber_regulator_only;
  logic                   io_hold;
  logic                   mem_retain;
  logic                   rtc_run;
  logic                   ctw_irq;
  int                     errors = 0;
  int                     samples_checked = 0;
  int                     cycles = 0;
  int                     irq_cnt = 0;
  int                     bad;
  int                     n;
  int                     irq0;
  int                     m_act;
  int                     m_alt;
  int                     m_en;
  int                     m_stat;
  logic [31:0]            rd;
  logic                   err;

  // The timewheel interrupt is fed back as a wake source when enabled.
  assign wake_src = wake_drv | {3'h0, ctw_irq & ctw_fb, 4'h0};

  pmc_ctrl #(.HIBER_WAKE_CYC(14'(HWC))) u_dut (
    .clk_sys(clk_sys), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .wake_src(wake_src), .rst_evt(rst_evt),
    .tick_1k(tick_1k), .subsys_clk_en(subsys_clk_en), .mode_q(mode_q),
    .regulators_on(regulators_on), .regulator_buzz(regulator_buzz),
    .hiber_regulator_only(hiber_regulator_only), .io_hold(io_hold),
    .mem_retain(mem_retain), .rtc_run(rtc_run), .ctw_irq(ctw_irq)
  );

  always #5 clk_sys = ~clk_sys;

  // Cycle limit and timewheel interrupt counter.
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (ctw_irq === 1'b1) begin
      irq_cnt <= irq_cnt + 1;
    end
    if (cycles == 20000) begin
      errors = errors + 1;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    if (errors == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic idle(input int k);
    repeat (k) @(posedge clk_sys);
  endtask

  // One APB transfer; the request is held until pready is sampled high.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp, "read data");
    chk(32'(err), 32'h0, "slave error");
  endtask

  task automatic wait_mode(input logic [1:0] m, output int k);
    k = 0;
    bad = 0;
    while (mode_q !== m && k < 3000) begin
      @(posedge clk_sys);
      k++;
      if (k > 2 && mode_q !== m && regulators_on !== 1'b1) bad++;
    end
  endtask

  task automatic tick();
    @(posedge clk_sys);
    tick_1k <= 1'b1;
    @(posedge clk_sys);
    tick_1k <= 1'b0;
    idle(5);
  endtask

  initial begin
    void'($urandom(68));
    repeat (12) @(posedge clk_sys);
    reset_n <= 1'b1;
    m_act = 8'hff;
    m_alt = 8'hfe;
    rdc(pmc_pkg::ACT_TPL_OFF, 32'h0000_00ff);
    rdc(pmc_pkg::ALT_TPL_OFF, 32'h0000_00fe);
    rdc(pmc_pkg::WAKE_EN_OFF, 32'h0);
    rdc(pmc_pkg::CTW_MASK_OFF, 32'h0000_03ff);
    rdc(pmc_pkg::MODE_OFF, 32'h0);
    chk(32'(subsys_clk_en), 32'h0000_00ff, "clock enables after reset");
    // Unmapped address: write ignored, read gives zero with an error.
    apb(1'b1, 8'h20, 32'hffff_ffff);
    apb(1'b0, 8'h20, 32'h0);
    chk(rd, 32'h0, "unmapped read");
    chk(32'(err), 32'h1, "unmapped error");
    // Template bits gate the subsystem clocks and may change at any time.
    m_act = $urandom & 8'hfe;
    wr(pmc_pkg::ACT_TPL_OFF, 32'(m_act));
    idle(2);
    chk(32'(subsys_clk_en), 32'(m_act), "active gating");
    m_act = m_act ^ (1 << ($urandom % 7 + 1));
    wr(pmc_pkg::ACT_TPL_OFF, 32'(m_act));
    rdc(pmc_pkg::ACT_TPL_OFF, 32'(m_act));
    idle(2);
    chk(32'(subsys_clk_en), 32'(m_act), "template change");
    // A wake event in active mode re-enables the processor.
    wr(pmc_pkg::WAKE_EN_OFF, 32'h1);
    wake_drv.comparator <= 1'b1;
    idle(3);
    wake_drv.comparator <= 1'b0;
    m_act = m_act | 1;
    idle(2);
    chk(32'(subsys_clk_en), 32'(m_act), "processor re-enabled");
    // Sleep: gated clocks, only enabled sleep sources wake, bounded wake time.
    m_act = m_act & 8'hfe;
    wr(pmc_pkg::ACT_TPL_OFF, 32'(m_act));
    m_en = 8'h08;
    wr(pmc_pkg::WAKE_EN_OFF, 32'(m_en));
    wr(pmc_pkg::MODE_OFF, 32'(pmc_pkg::MODE_SLEEP));
    idle(3);
    chk(32'(mode_q), 32'(pmc_pkg::MODE_SLEEP), "sleep entry");
    chk(32'(subsys_clk_en), 32'h0, "sleep gating");
    chk(32'(rtc_run), 32'h1, "clock alive in sleep");
    chk(32'(regulator_buzz), 32'h1, "regulators buzzed");
    wake_drv.comparator <= 1'b1;
    idle(10);
    chk(32'(mode_q), 32'(pmc_pkg::MODE_SLEEP), "disabled source");
    wake_drv.comparator <= 1'b0;
    wake_drv.rtc <= 1'b1;
    wait_mode(pmc_pkg::MODE_ACTIVE, n);
    wake_drv.rtc <= 1'b0;
    chk(32'(n >= 1499 && n <= 1504), 32'h1, "sleep wake time");
    chk(32'(bad), 32'h0, "regulators during wake");
    m_act = m_act | 1;
    idle(2);
    chk(32'(subsys_clk_en), 32'(m_act), "processor after sleep");
    // Hibernate: retention, holds, and of the interrupts only the pin interrupt wakes.
    m_alt = $urandom & 8'hff;
    wr(pmc_pkg::ALT_TPL_OFF, 32'(m_alt));
    m_en = 8'h03;
    wr(pmc_pkg::WAKE_EN_OFF, 32'(m_en));
    wr(pmc_pkg::MODE_OFF, 32'(pmc_pkg::MODE_HIBER));
    idle(3);
    chk(32'(mode_q), 32'(pmc_pkg::MODE_HIBER), "hibernate entry");
    chk(32'(subsys_clk_en), 32'h0, "hibernate clocks");
    chk(32'(mem_retain), 32'h1, "memory retained");
    chk(32'(hiber_regulator_only), 32'h1, "hibernate regulator");
    chk(32'(io_hold), 32'h1, "pins held");
    wake_drv.comparator <= 1'b1;
    rst_evt.watchdog_reset <= 1'b1;
    idle(30);
    chk(32'(mode_q), 32'(pmc_pkg::MODE_HIBER), "hibernate stays");
    wake_drv.comparator <= 1'b0;
    rst_evt.watchdog_reset <= 1'b0;
    idle(1);
    wake_drv.pin_interrupt_unit <= 1'b1;
    wait_mode(pmc_pkg::MODE_ACTIVE, n);
    wake_drv.pin_interrupt_unit <= 1'b0;
    chk(32'(n >= HWC && n <= HWC + 5), 32'h1, "hibernate wake time");
    rdc(pmc_pkg::ALT_TPL_OFF, 32'(m_alt));
    rdc(pmc_pkg::WAKE_EN_OFF, 32'(m_en));
    // Every source in alternate active mode, enabled or not.
    m_en = $urandom & 8'hef;
    m_stat = 0;
    wr(pmc_pkg::WAKE_EN_OFF, 32'(m_en));
    wr(pmc_pkg::WAKE_STAT_OFF, 32'h7ff);
    for (int i = 0; i < 8; i++) begin
      wr(pmc_pkg::MODE_OFF, 32'(pmc_pkg::MODE_ALT));
      idle(2);
      chk(32'(mode_q), 32'(pmc_pkg::MODE_ALT), "alternate entry");
      chk(32'(subsys_clk_en), 32'(m_alt), "alternate gating");
      wake_drv <= 8'(1 << i);
      idle(4);
      chk(32'(mode_q), m_en[i] ? 32'h0 : 32'h1, "wake by source");
      wake_drv <= 8'h00;
      if (m_en[i]) m_stat = m_stat | (1 << i);
      wr(pmc_pkg::MODE_OFF, 32'(pmc_pkg::MODE_ACTIVE));
    end
    rdc(pmc_pkg::WAKE_STAT_OFF, 32'(m_stat));
    // Reset-type events wake from alternate active and are recorded.
    wr(pmc_pkg::WAKE_STAT_OFF, 32'h7ff);
    for (int j = 0; j < 3; j++) begin
      wr(pmc_pkg::MODE_OFF, 32'(pmc_pkg::MODE_ALT));
      idle(2);
      rst_evt <= 3'(1 ^ (1 << j));
      idle(4);
      chk(32'(mode_q), 32'h0, "reset event wake");
      rst_evt <= 3'h1;
    end
    rdc(pmc_pkg::WAKE_STAT_OFF, 32'h0000_0700);
    wr(pmc_pkg::WAKE_STAT_OFF, 32'h7ff);
    rdc(pmc_pkg::WAKE_STAT_OFF, 32'h0);
    // Timewheel counts ticks and its periodic interrupt wakes the chip.
    wr(pmc_pkg::WAKE_EN_OFF, 32'h10);
    wr(pmc_pkg::CTW_MASK_OFF, 32'h3);
    rdc(pmc_pkg::CTW_MASK_OFF, 32'h3);
    wr(pmc_pkg::CTW_CNT_OFF, 32'h1);
    wr(pmc_pkg::MODE_OFF, 32'(pmc_pkg::MODE_ALT));
    ctw_fb <= 1'b1;
    irq0 = irq_cnt;
    for (int t = 1; t <= 4; t++) begin
      tick();
      chk(32'(mode_q), t < 4 ? 32'h1 : 32'h0, "timewheel wake");
    end
    ctw_fb <= 1'b0;
    repeat (4) tick();
    rdc(pmc_pkg::CTW_CNT_OFF, 32'h8);
    chk(32'(irq_cnt - irq0), 32'h2, "timewheel interrupts");
    tally_and_finish();
  end
endmodule
